//--- design/wsc_consts.vh
// Constants for the weigher stream and set-up command interpreter
`ifndef WSC_CONSTS_VH
`define WSC_CONSTS_VH
// APB byte offsets
`define WSC_A_CMD 8'h00
`define WSC_A_PARAM 8'h04
`define WSC_A_PASS 8'h08
`define WSC_A_RESP 8'h0c
`define WSC_A_RVAL 8'h10
`define WSC_A_CODE 8'h14
`define WSC_A_LINK 8'h18
`define WSC_A_RATE 8'h1c
// Command register fields
`define WSC_CODE_MSB 4
`define WSC_HASP_BIT 8
// Command codes
`define WSC_C_SGROSS 5'h01
`define WSC_C_SNET 5'h02
`define WSC_C_SLONG 5'h03
`define WSC_C_NODE 5'h04
`define WSC_C_RATE 5'h05
`define WSC_C_DUPLEX 5'h06
`define WSC_C_SAVE 5'h07
`define WSC_C_SERIAL 5'h08
`define WSC_C_UNLOCK 5'h09
`define WSC_C_COMMIT 5'h0a
`define WSC_C_CZERO 5'h0b
`define WSC_C_CGAIN 5'h0c
`define WSC_C_UPPER 5'h0d
`define WSC_C_LOWER 5'h0e
`define WSC_C_STEP 5'h0f
`define WSC_C_POINT 5'h10
`define WSC_C_ZTBAND 5'h11
`define WSC_C_ZTRANGE 5'h12
`define WSC_C_DEFAULTS 5'h13
`define WSC_C_FTYPE 5'h14
`define WSC_C_FLEVEL 5'h15
`define WSC_C_URATE 5'h16
`define WSC_C_MRANGE 5'h17
`define WSC_C_MTIME 5'h18
`define WSC_C_SELECT 5'h19
// Response codes
`define WSC_R_NONE 2'h0
`define WSC_R_OK 2'h1
`define WSC_R_ERR 2'h2
`define WSC_R_VAL 2'h3
// Nonvolatile write kinds
`define WSC_NV_IND 2'h1
`define WSC_NV_CAL 2'h2
`define WSC_NV_SER 2'h3
// Reset and limit values
`define WSC_RATE_DEF 32'h0001c200
`define WSC_NODE_MAX 32'h000000ff
`define WSC_SERIAL_MAX 32'h05f5e0ff
`define WSC_FLEVEL_MAX 32'h00000008
`define WSC_URATE_MAX 32'h00000007
`define WSC_BIN_MAX 32'h00000001
// String layout
`define WSC_SUM_LEN 5'd17
`define WSC_LONG_CR 5'd19
`define WSC_CR 8'h0d
`endif

//--- design/wsc_interp.v
// Weigher stream, communication set-up and calibration command interpreter
`timescale 1ns/10ps
`include "wsc_consts.vh"
module wsc_interp #(
	parameter SERIAL_PASSWORD = 32'h00050992
) (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire grossNeg,
	input wire [23:0] grossBcd,
	input wire netNeg,
	input wire [23:0] netBcd,
	input wire sigStable,
	input wire zeroDone,
	input wire tareActive,
	input wire [31:0] rawSample,
	input wire [7:0] nvmNode,
	input wire [31:0] nvmRate,
	input wire [15:0] nvmCode,
	output reg [7:0] txData,
	output reg txValid,
	input wire txReady,
	output reg [7:0] nodeAddr,
	output reg [31:0] lineRate,
	output reg duplexFull,
	output reg nvmWrite,
	output reg [1:0] nvmKind
);
	localparam M_IDLE = 4'b0001;
	localparam M_GROSS = 4'b0010;
	localparam M_NET = 4'b0100;
	localparam M_LONG = 4'b1000;

	// ==========================================================
	// APB slave
	wire acc = psel & penable & pready;
	wire wrAcc = acc & pwrite;
	wire [4:0] cmdCode = pwdata[`WSC_CODE_MSB:0];
	wire cmdHasP = pwdata[`WSC_HASP_BIT];
	reg selected_q;
	wire cmdStb = wrAcc & (paddr == `WSC_A_CMD) & ~pslverr &
		(selected_q | cmdCode == `WSC_C_SELECT);
	reg [31:0] param_q;
	reg [31:0] pass_q;
	reg [8:0] lastCmd_q;
	reg [1:0] respCode_q;
	reg [31:0] respVal_q;
	reg [15:0] code_q;
	reg unlocked_q;
	reg [3:0] mode_q;
	reg [31:0] mem [0:31];
	reg [31:0] rdMux;
	reg mapped;

	always @* begin
		mapped = 1'b1;
		rdMux = 32'h00000000;
		case (paddr)
		`WSC_A_CMD: rdMux = {23'h000000, lastCmd_q};
		`WSC_A_PARAM: rdMux = param_q;
		`WSC_A_PASS: rdMux = pass_q;
		`WSC_A_RESP: rdMux = {21'h000000, mode_q, selected_q,
			4'h0, respCode_q};
		`WSC_A_RVAL: rdMux = respVal_q;
		`WSC_A_CODE: rdMux = {15'h0000, unlocked_q, code_q};
		`WSC_A_LINK: rdMux = {15'h0000, duplexFull,
			mem[`WSC_C_NODE][7:0], nodeAddr};
		`WSC_A_RATE: rdMux = lineRate;
		default: mapped = 1'b0;
		endcase
	end

	// Zero-wait slave: pready rises in the access phase of every transfer
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			param_q <= 32'h00000000;
			pass_q <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel & ~penable)
				prdata <= mapped ? rdMux : 32'h00000000;
			if (wrAcc & paddr == `WSC_A_PARAM)
				param_q <= pwdata;
			if (wrAcc & paddr == `WSC_A_PASS)
				pass_q <= pwdata;
		end
	end

	// ==========================================================
	// Command interpreter
	function isCalParam;
		input [4:0] c;
		begin
			isCalParam = (c == `WSC_C_UPPER) | (c == `WSC_C_LOWER) |
				(c == `WSC_C_STEP) | (c == `WSC_C_POINT) |
				(c == `WSC_C_ZTBAND) | (c == `WSC_C_ZTRANGE) |
				(c == `WSC_C_CGAIN);
		end
	endfunction

	function [31:0] limitOf;
		input [4:0] c;
		begin
			case (c)
			`WSC_C_NODE: limitOf = `WSC_NODE_MAX;
			`WSC_C_DUPLEX: limitOf = `WSC_BIN_MAX;
			`WSC_C_FTYPE: limitOf = `WSC_BIN_MAX;
			`WSC_C_FLEVEL: limitOf = `WSC_FLEVEL_MAX;
			`WSC_C_URATE: limitOf = `WSC_URATE_MAX;
			default: limitOf = 32'hffffffff;
			endcase
		end
	endfunction

	wire isInd = (cmdCode == `WSC_C_NODE) | (cmdCode == `WSC_C_RATE) |
		(cmdCode == `WSC_C_DUPLEX) | (cmdCode >= `WSC_C_FTYPE &
		cmdCode <= `WSC_C_MTIME);
	wire protAct = (cmdHasP & isCalParam(cmdCode)) |
		(cmdCode == `WSC_C_CZERO) | (cmdCode == `WSC_C_COMMIT) |
		(cmdCode == `WSC_C_DEFAULTS);
	reg loaded_q;
	integer i;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 32; i = i + 1)
				mem[i] <= 32'h00000000;
			mem[`WSC_C_RATE] <= `WSC_RATE_DEF;
			loaded_q <= 1'b0;
			nodeAddr <= 8'h00;
			lineRate <= `WSC_RATE_DEF;
			duplexFull <= 1'b0;
			code_q <= 16'h0000;
			unlocked_q <= 1'b0;
			selected_q <= 1'b1;
			mode_q <= M_IDLE;
			respCode_q <= `WSC_R_NONE;
			respVal_q <= 32'h00000000;
			lastCmd_q <= 9'h000;
			nvmWrite <= 1'b0;
			nvmKind <= 2'h0;
		end else begin
			nvmWrite <= 1'b0;
			duplexFull <= mem[`WSC_C_DUPLEX][0];
			if (!loaded_q) begin
				// Saved link settings act only here, on the first cycle after each reset
				loaded_q <= 1'b1;
				nodeAddr <= nvmNode;
				lineRate <= nvmRate;
				mem[`WSC_C_NODE] <= {24'h000000, nvmNode};
				mem[`WSC_C_RATE] <= nvmRate;
				code_q <= nvmCode;
				selected_q <= (nvmNode == 8'h00);
			end else if (cmdStb) begin
				lastCmd_q <= {cmdHasP, 3'h0, cmdCode};
				unlocked_q <= 1'b0;
				mode_q <= M_IDLE;
				respCode_q <= `WSC_R_OK;
				respVal_q <= 32'h00000000;
				if (protAct && !unlocked_q) begin
					respCode_q <= `WSC_R_ERR;
				end else if (isInd | isCalParam(cmdCode)) begin
					if (!cmdHasP) begin
						respCode_q <= `WSC_R_VAL;
						respVal_q <= mem[cmdCode];
					end else if (param_q > limitOf(cmdCode)) begin
						respCode_q <= `WSC_R_ERR;
					end else if (cmdCode == `WSC_C_RATE &&
						param_q == 32'h00000000) begin
						respCode_q <= `WSC_R_ERR;
					end else begin
						mem[cmdCode] <= param_q;
					end
				end else begin
					case (cmdCode)
					`WSC_C_SGROSS: mode_q <= M_GROSS;
					`WSC_C_SNET: mode_q <= M_NET;
					`WSC_C_SLONG: mode_q <= M_LONG;
					`WSC_C_SELECT: begin
						// Address zero never drops selection
						selected_q <= nodeAddr == 8'h00 ||
							param_q == {24'h000000, nodeAddr};
						if (nodeAddr != 8'h00 &&
							param_q != {24'h000000, nodeAddr})
							respCode_q <= `WSC_R_NONE;
					end
					`WSC_C_SAVE: begin
						nvmWrite <= 1'b1;
						nvmKind <= `WSC_NV_IND;
					end
					`WSC_C_SERIAL: begin
						if (!cmdHasP) begin
							respCode_q <= `WSC_R_VAL;
							respVal_q <= mem[`WSC_C_SERIAL];
						end else if (pass_q != SERIAL_PASSWORD ||
							param_q > `WSC_SERIAL_MAX) begin
							respCode_q <= `WSC_R_ERR;
						end else begin
							mem[`WSC_C_SERIAL] <= param_q;
							nvmWrite <= 1'b1;
							nvmKind <= `WSC_NV_SER;
						end
					end
					`WSC_C_UNLOCK: begin
						if (!cmdHasP) begin
							respCode_q <= `WSC_R_VAL;
							respVal_q <= {16'h0000, code_q};
						end else if (param_q == {16'h0000, code_q}) begin
							unlocked_q <= 1'b1;
						end else begin
							respCode_q <= `WSC_R_ERR;
						end
					end
					`WSC_C_COMMIT: begin
						nvmWrite <= 1'b1;
						nvmKind <= `WSC_NV_CAL;
						code_q <= code_q + 16'h0001;
					end
					`WSC_C_CZERO:
						mem[`WSC_C_CZERO] <= rawSample;
					`WSC_C_DEFAULTS: begin
						// Serial number is identity, not a setting
						for (i = 0; i < 32; i = i + 1)
							if (i != `WSC_C_SERIAL)
								mem[i] <= 32'h00000000;
						mem[`WSC_C_RATE] <= `WSC_RATE_DEF;
					end
					default: respCode_q <= `WSC_R_ERR;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Stream string generator
	reg [4:0] idx_q;
	reg [7:0] sum_q;
	reg snapNeg_q;
	reg [23:0] snapDig_q;
	reg snapNeg2_q;
	reg [23:0] snapDig2_q;
	reg [2:0] snapStat_q;
	reg [7:0] ch;
	reg last;
	reg [2:0] pt;
	reg [2:0] dk;
	wire [7:0] ckByte = ~sum_q;

	function [7:0] digCh;
		input [23:0] b;
		input [2:0] k;
		begin
			digCh = {4'h3, b[(3'd5 - k) * 4 +: 4]};
		end
	endfunction

	function [7:0] hexCh;
		input [3:0] n;
		begin
			hexCh = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
		end
	endfunction

	// Sign and digits come from the snapshot taken on the first character,
	// so a string never mixes two weight samples.
	always @* begin
		ch = `WSC_CR;
		last = 1'b0;
		dk = 3'h0;
		pt = (mem[`WSC_C_POINT] > 32'h00000005) ? 3'h0 :
			mem[`WSC_C_POINT][2:0];
		if (mode_q == M_LONG) begin
			case (idx_q)
			5'd0: ch = 8'h57;
			5'd1: ch = snapNeg_q ? 8'h2d : 8'h2b;
			5'd8: ch = snapNeg2_q ? 8'h2d : 8'h2b;
			5'd15: ch = 8'h30;
			5'd16: ch = {5'h06, snapStat_q};
			5'd17: ch = hexCh(ckByte[7:4]);
			5'd18: ch = hexCh(ckByte[3:0]);
			5'd19: last = 1'b1;
			default: begin
				if (idx_q < 5'd8) begin
					dk = idx_q[2:0] - 3'd2;
					ch = digCh(snapDig_q, dk);
				end else begin
					dk = idx_q[2:0] - 3'd1;
					ch = digCh(snapDig2_q, dk);
				end
			end
			endcase
		end else begin
			if (idx_q == 5'd0)
				ch = (mode_q == M_NET) ? 8'h4e : 8'h47;
			else if (idx_q == 5'd1)
				ch = snapNeg_q ? 8'h2d : 8'h2b;
			else if (idx_q == 5'd8 + {4'h0, pt != 3'h0})
				last = 1'b1;
			else if (pt != 3'h0 && idx_q == 5'd8 - {2'h0, pt})
				ch = 8'h2e;
			else begin
				dk = idx_q[2:0] - 3'd2;
				if (pt != 3'h0 && idx_q > 5'd8 - {2'h0, pt})
					dk = dk - 3'd1;
				ch = digCh(snapDig_q, dk);
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txData <= 8'h00;
			txValid <= 1'b0;
			idx_q <= 5'd0;
			sum_q <= 8'h00;
			snapNeg_q <= 1'b0;
			snapDig_q <= 24'h000000;
			snapNeg2_q <= 1'b0;
			snapDig2_q <= 24'h000000;
			snapStat_q <= 3'h0;
		end else begin
			if (txValid & txReady)
				txValid <= 1'b0;
			if (cmdStb) begin
				idx_q <= 5'd0;
			end else if (mode_q != M_IDLE && (!txValid || txReady)) begin
				txData <= ch;
				txValid <= 1'b1;
				idx_q <= last ? 5'd0 : idx_q + 5'd1;
				if (idx_q == 5'd0) begin
					sum_q <= ch;
					snapNeg_q <= (mode_q == M_GROSS) ? grossNeg : netNeg;
					snapDig_q <= (mode_q == M_GROSS) ? grossBcd : netBcd;
					snapNeg2_q <= grossNeg;
					snapDig2_q <= grossBcd;
					snapStat_q <= {tareActive, zeroDone, sigStable};
				end else if (idx_q < `WSC_SUM_LEN) begin
					sum_q <= sum_q + ch;
				end
			end
		end
	end
endmodule // wsc_interp

//--- test/wsc_sink.sv
// Host-side receiver for the weight stream
`timescale 1ns/10ps
module wsc_sink (
	input wire clk,
	input wire rst_b,
	input wire stall,
	input wire [7:0] txData,
	input wire txValid,
	output logic txReady,
	output logic got,
	output logic [7:0] gotData
);
	// ==========
	// Receiver
	// Random back-pressure keeps the held-character path busy
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txReady <= 1'h0;
			got <= 1'h0;
		end else begin
			txReady <= !stall;
			got <= txValid && txReady;
			gotData <= txData;
		end
	end
endmodule // wsc_sink

//--- test/wsc_interp_assertions.sv
// Port assertions for the weigher command interpreter
`timescale 1ns/10ps
`include "wsc_consts.vh"
module wsc_interp_assertions (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [7:0] txData,
	input wire txValid,
	input wire txReady,
	input wire [7:0] nodeAddr,
	input wire [31:0] lineRate,
	input wire nvmWrite,
	input wire [1:0] nvmKind
);
	// ==========
	// Command history
	// Two cycles of history accept a strobe one edge late
	wire cmdAcc = psel && penable && pready && pwrite && paddr == `WSC_A_CMD;
	wire [1:0] sel = pwdata[1:0];
	wire [7:0] letter = sel == 2'h1 ? 8'h47 : sel == 2'h2 ? 8'h4e : 8'h57;
	reg [4:0] code1_q;
	reg [4:0] code2_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			code1_q <= 5'h00;
			code2_q <= 5'h00;
		end else begin
			code1_q <= cmdAcc ? pwdata[4:0] : 5'h00;
			code2_q <= code1_q;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_streamCmd;
		cmdAcc && pwdata[4:0] inside {[5'h01:5'h03]} && !txValid;
	endsequence
	// The mode register turns over on the access edge, so the first
	// character is launched one edge later and seen on the second
	sequence s_firstChar;
		txValid && txData == $past(letter, 2);
	endsequence
	property p_start;
		s_streamCmd |-> ##2 s_firstChar;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_hold;
		txValid && !txReady |=> txValid && $stable(txData);
	endproperty
	a_hold: assert property (p_hold) else $error("char not held");
	property p_node;
		$past(rst_b) && $past(rst_b, 2) |-> $stable(nodeAddr);
	endproperty
	a_node: assert property (p_node) else $error("node moved");
	property p_rate;
		$past(rst_b) && $past(rst_b, 2) |-> $stable(lineRate);
	endproperty
	a_rate: assert property (p_rate) else $error("rate moved");
	property p_commit;
		nvmWrite && nvmKind == `WSC_NV_CAL |->
			code1_q == `WSC_C_COMMIT || code2_q == `WSC_C_COMMIT;
	endproperty
	a_commit: assert property (p_commit) else $error("cal write");
	property p_save;
		nvmWrite && nvmKind == `WSC_NV_IND |->
			code1_q == `WSC_C_SAVE || code2_q == `WSC_C_SAVE;
	endproperty
	a_save: assert property (p_save) else $error("save write");
	property p_serial;
		nvmWrite && nvmKind == `WSC_NV_SER |->
			code1_q == `WSC_C_SERIAL || code2_q == `WSC_C_SERIAL;
	endproperty
	a_serial: assert property (p_serial) else $error("serial write");
	property p_pulse;
		nvmWrite |=> !nvmWrite;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long strobe");
endmodule // wsc_interp_assertions
bind wsc_interp wsc_interp_assertions chk (.clk(clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .txData(txData), .txValid(txValid),
	.txReady(txReady), .nodeAddr(nodeAddr), .lineRate(lineRate),
	.nvmWrite(nvmWrite), .nvmKind(nvmKind));

//--- test/weigher_stream_and_setup_cmds_bench.sv
// Self-checking bench for the weigher command interpreter
`timescale 1ns/10ps
`include "wsc_consts.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module weigher_stream_and_setup_cmds_bench;
	localparam PW = 32'h00050992;
	localparam DP = 3;
	logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, stall = 1'h0, grossNeg = 1'h0, netNeg = 1'h0;
	logic sigStable = 1'h0, zeroDone = 1'h0, tareActive = 1'h0, er;
	logic [7:0] paddr = 8'h00, nvmNode = 8'h00;
	logic [15:0] nvmCode = 16'h0010;
	logic [23:0] grossBcd = 24'h0, netBcd = 24'h0;
	logic [31:0] pwdata = 32'h0, rawSample = 32'h0, rd;
	logic [31:0] nvmRate = 32'h00002580;
	logic [31:0] rnd = 32'hbacf9846, sr = 32'hbacf9846;
	logic [1:0] kind = 2'h0;
	logic [7:0] exp[$], rx[$];
	int failures = 0, checks = 0, cyc = 0, k, i, access_code;
	wire [31:0] prdata, lineRate;
	wire [7:0] txData, nodeAddr, gotData;
	wire [1:0] nvmKind;
	wire pready, pslverr, txValid, txReady, duplexFull, nvmWrite, got;
	wsc_interp #(.SERIAL_PASSWORD(PW)) dut (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .grossNeg(grossNeg), .grossBcd(grossBcd),
		.netNeg(netNeg), .netBcd(netBcd), .sigStable(sigStable),
		.zeroDone(zeroDone), .tareActive(tareActive),
		.rawSample(rawSample), .nvmNode(nvmNode), .nvmRate(nvmRate),
		.nvmCode(nvmCode), .txData(txData), .txValid(txValid),
		.txReady(txReady), .nodeAddr(nodeAddr), .lineRate(lineRate),
		.duplexFull(duplexFull), .nvmWrite(nvmWrite), .nvmKind(nvmKind));
	wsc_sink host (.clk(clk), .rst_b(rst_b), .stall(stall),
		.txData(txData), .txValid(txValid), .txReady(txReady), .got(got),
		.gotData(gotData));
	// ==========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] hx(input logic [3:0] n);
		return n < 4'ha ? 8'h30 + n : 8'h57 + n;
	endfunction
	task automatic put(input logic s, input logic [23:0] b);
		exp.push_back(s ? "-" : "+");
		for (int j = 5; j >= 0; j--)
			exp.push_back(8'h30 + b[j*4+:4]);
	endtask
	task automatic build(input int m);
		logic [7:0] s;
		exp = {};
		exp.push_back(m == 1 ? "G" : m == 2 ? "N" : "W");
		if (m != 1) put(netNeg, netBcd);
		if (m != 2) put(grossNeg, grossBcd);
		// Point leaves DP digits after it; the long string carries none
		if (m != 3) exp.insert(8 - DP, ".");
		if (m == 3) begin
			exp.push_back("0");
			exp.push_back({5'h06, tareActive, zeroDone, sigStable});
			s = 8'h00;
			foreach (exp[j]) s += exp[j];
			exp.push_back(hx(~s[7:4]));
			exp.push_back(hx(~s[3:0]));
		end
		exp.push_back(`WSC_CR);
	endtask
	// The access phase is held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic cmd(input logic [4:0] c, input logic h,
		input logic [31:0] p, input int ex, input int ev);
		apb(1'h1, `WSC_A_PARAM, p);
		apb(1'h1, `WSC_A_CMD, {23'h0, h, 3'h0, c});
		apb(1'h0, `WSC_A_RESP, 32'h0);
		if (ex >= 0) `CHK(rd[1:0], ex[1:0])
		apb(1'h0, `WSC_A_RVAL, 32'h0);
		if (ev >= 0) `CHK(rd, ev[31:0])
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		sr <= lfsr(sr);
		stall <= sr[0] & sr[3];
		if (got === 1'h1)
			rx.push_back(gotData inside {[8'h41:8'h46]} ? gotData | 8'h20 : gotData);
		if (nvmWrite === 1'h1) kind <= nvmKind;
		if (cyc == 6000) begin
			failures++;
			complete_run;
		end
	end
	// ==========
	// Scenarios
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, `WSC_A_CODE, 32'h0);
		`CHK({rd[15:0], nodeAddr, lineRate}, {nvmCode, 8'h00, nvmRate})
		apb(1'h0, 8'h20, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		apb(1'h0, `WSC_A_RESP, 32'h0);
		`CHK(rd[6], 1'h1)
		cmd(`WSC_C_NODE, 1'h1, 32'hff, `WSC_R_OK, -1);
		cmd(`WSC_C_NODE, 1'h1, 32'h100, `WSC_R_ERR, -1);
		cmd(`WSC_C_NODE, 1'h0, 32'h0, `WSC_R_VAL, 255);
		cmd(`WSC_C_RATE, 1'h0, 32'h0, `WSC_R_VAL, nvmRate);
		cmd(`WSC_C_RATE, 1'h1, `WSC_RATE_DEF, `WSC_R_OK, -1);
		`CHK({nodeAddr, lineRate}, {8'h00, nvmRate})
		for (k = 0; k < 3; k++) begin
			cmd(`WSC_C_DUPLEX, 1'h1, k, k < 2 ? 1 : 2, -1);
			`CHK(duplexFull, k != 0)
		end
		cmd(`WSC_C_SAVE, 1'h0, 32'h0, `WSC_R_OK, -1);
		`CHK(kind, `WSC_NV_IND)
		access_code = nvmCode;
		cmd(`WSC_C_STEP, 1'h0, 32'h0, `WSC_R_VAL, -1);
		cmd(`WSC_C_STEP, 1'h1, 32'h5, `WSC_R_ERR, -1);
		cmd(`WSC_C_UNLOCK, 1'h0, 32'h0, `WSC_R_VAL, access_code);
		cmd(`WSC_C_UNLOCK, 1'h1, access_code + 1, `WSC_R_ERR, -1);
		cmd(`WSC_C_UNLOCK, 1'h1, access_code, `WSC_R_OK, -1);
		cmd(`WSC_C_STEP, 1'h1, 32'h5, `WSC_R_OK, -1);
		cmd(`WSC_C_STEP, 1'h1, 32'h6, `WSC_R_ERR, -1);
		cmd(`WSC_C_STEP, 1'h0, 32'h0, `WSC_R_VAL, 5);
		cmd(`WSC_C_COMMIT, 1'h0, 32'h0, `WSC_R_ERR, -1);
		for (k = `WSC_C_CZERO; k <= `WSC_C_DEFAULTS; k++) begin
			cmd(k[4:0], 1'h1, 32'h1, `WSC_R_ERR, -1);
			cmd(`WSC_C_UNLOCK, 1'h1, access_code, `WSC_R_OK, -1);
			cmd(k[4:0], 1'h1, 32'h1, `WSC_R_OK, -1);
		end
		cmd(`WSC_C_STEP, 1'h0, 32'h0, `WSC_R_VAL, 0);
		cmd(`WSC_C_UNLOCK, 1'h1, access_code, `WSC_R_OK, -1);
		cmd(`WSC_C_COMMIT, 1'h0, 32'h0, `WSC_R_OK, -1);
		`CHK(kind, `WSC_NV_CAL)
		access_code++;
		cmd(`WSC_C_UNLOCK, 1'h0, 32'h0, `WSC_R_VAL, access_code);
		rnd = lfsr(rnd);
		i = rnd % 100000000;
		apb(1'h1, `WSC_A_PASS, PW + 1);
		cmd(`WSC_C_SERIAL, 1'h1, i, `WSC_R_ERR, -1);
		apb(1'h1, `WSC_A_PASS, PW);
		cmd(`WSC_C_SERIAL, 1'h1, i, `WSC_R_OK, -1);
		`CHK(kind, `WSC_NV_SER)
		cmd(`WSC_C_SERIAL, 1'h0, 32'h0, `WSC_R_VAL, i);
		cmd(`WSC_C_UNLOCK, 1'h1, access_code, `WSC_R_OK, -1);
		cmd(`WSC_C_POINT, 1'h1, DP, `WSC_R_OK, -1);
		for (k = 1; k <= 3; k++) begin
			rnd = lfsr(rnd);
			{grossNeg, netNeg, sigStable, zeroDone, tareActive} <= rnd[4:0];
			rawSample <= rnd;
			for (i = 0; i < 6; i++) begin
				rnd = lfsr(rnd);
				grossBcd[i*4+:4] <= rnd[3:0] % 4'ha;
				netBcd[i*4+:4] <= rnd[7:4] % 4'ha;
			end
			@(posedge clk);
			build(k);
			rx = {};
			cmd(k[4:0], 1'h0, 32'h0, -1, -1);
			apb(1'h0, `WSC_A_RESP, 32'h0);
			`CHK(rd[10:7], 4'h1 << k)
			while (rx.size() < 2 * exp.size()) @(posedge clk);
			for (i = 0; i < 2 * exp.size(); i++)
				`CHK(rx[i], exp[i % exp.size()])
			cmd(`WSC_C_NODE, 1'h0, 32'h0, `WSC_R_VAL, -1);
			rx = {};
			repeat (20) @(posedge clk);
			`CHK(rx.size() < 2, 1'h1)
		end
		rst_b <= 1'h0;
		nvmNode <= 8'h05;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, `WSC_A_RESP, 32'h0);
		`CHK({rd[6], nodeAddr}, 9'h005)
		apb(1'h1, `WSC_A_PARAM, 32'h1);
		apb(1'h1, `WSC_A_CMD, 32'h106);
		repeat (2) @(posedge clk);
		`CHK(duplexFull, 1'h0)
		cmd(`WSC_C_SELECT, 1'h1, 32'h4, `WSC_R_NONE, -1);
		cmd(`WSC_C_SELECT, 1'h1, 32'h5, `WSC_R_OK, -1);
		cmd(`WSC_C_DUPLEX, 1'h1, 32'h1, `WSC_R_OK, -1);
		`CHK(duplexFull, 1'h1)
		complete_run;
	end
endmodule // weigher_stream_and_setup_cmds_bench
